// *** verilog/lcd_scan_pkg.sv ***
// Purpose: Constants for the column driver RAM and scan logic
// Assumes: 8-bit host bus, 64 columns, 8 pages
// Notes: Instruction codes are on the upper data bits
package lcd_scan_pkg;
    localparam int COL_W = 6;
    localparam int PAGE_W = 3;
    localparam int LINE_W = 6;
    localparam int SEG_N = 64;
    localparam int RAM_DEPTH = 512;
    localparam logic [COL_W-1:0] COL_MAX = 6'h3F;
    localparam logic [COL_W-1:0] COL_RST = 6'h00;
    localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
    localparam logic [LINE_W-1:0] START_RST = 6'h00;
    localparam logic [6:0] ONOFF_CODE = 7'h1F;
    localparam logic [1:0] START_CODE = 2'h3;
    localparam logic [4:0] PAGE_CODE = 5'h17;
    localparam logic [1:0] COL_CODE = 2'h1;
    localparam int BUSY_BIT = 7;
    localparam int OFF_BIT = 5;
    localparam int RST_BIT = 4;
    // Busy time after each accepted access, in ns; BUSY_CYC rounds it up to cycles of 4 ns
    localparam int BUSY_NS = 8;
    localparam int BUSY_CYC = (BUSY_NS + 3) / 4;
    // Drive level codes
    localparam logic [1:0] LVL_V1 = 2'h0;
    localparam logic [1:0] LVL_V2 = 2'h1;
    localparam logic [1:0] LVL_V3 = 2'h2;
    localparam logic [1:0] LVL_V4 = 2'h3;
endpackage

// *** verilog/seg_level_sel.sv ***
// Purpose: One segment drive level selector
// Assumes: Inputs are synchronous to clock_i
// Notes: Registered output
`timescale 1ns/100ps
`default_nettype none
module seg_level_sel (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Data and polarity
    input wire logic data_i,
    input wire logic polarity_i,
    // Drive level
    output logic [1:0] level_o
);
    import lcd_scan_pkg::*;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            level_o <= LVL_V2;
        end else begin
            unique case ({polarity_i, data_i})
                2'h3: level_o <= LVL_V1;
                2'h2: level_o <= LVL_V3;
                2'h1: level_o <= LVL_V2;
                2'h0: level_o <= LVL_V4;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** verilog/lcd_column_ram_scan_control.sv ***
// Purpose: Display RAM addressing, host access and refresh scan of a column driver
// Assumes: Host strobe, line shift clock and frame start are asynchronous pins
// Notes: Host access acts on the falling edge of the enable strobe
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Page register loads only by instruction
// - Column counter loads, increments per data access
// - Column counter wraps 63 to 0
// - RAM bit one lights dot
// - Segment order select reverses column mapping
// - Six-bit line counter steps on clock fall
// - Frame start presets line counter from start
// - Output latch captures row on clock rise
// - Display off blanks latch, RAM untouched
// - Data and polarity pick four levels
// - Reset low: display off, start zero
// - Under reset only status read accepted
// - Busy accepts only status read
// - On/off instruction uses lowest data bit
// - Code 11 loads start line register
// - Code 10111 loads page register
// - Code 01 loads column counter
// - Status: busy 7, off 5, reset 4
// - Data read returns prior latch, then fetches
module lcd_column_ram_scan_control (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Host bus
    input wire logic host_enable_i,
    input wire logic host_read_i,
    input wire logic host_data_sel_i,
    input wire logic [7:0] host_bus_lines_i,
    output logic [7:0] host_bus_lines_o,
    output logic host_bus_lines_oe_o,
    // Device pins
    input wire logic reset_n_i,
    input wire logic seg_order_i,
    input wire logic line_shift_clock_i,
    input wire logic frame_start_i,
    input wire logic polarity_i,
    // Segment drive
    output logic [2*lcd_scan_pkg::SEG_N-1:0] seg_level_o,
    output logic display_on_o
);
    import lcd_scan_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [10:0] bus_sync1_reg;
    logic [10:0] bus_sync2_reg;
    logic en_d_reg;
    logic cl_d_reg;
    // Device reset reads as asserted until the pin has been synchronised
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {seg_order_i, frame_start_i, line_shift_clock_i,
                          host_enable_i, reset_n_i};
            sync2_reg <= sync1_reg;
        end
    end
    wire logic rst_n_s = sync2_reg[0];
    wire logic en_s = sync2_reg[1];
    wire logic cl_s = sync2_reg[2];
    wire logic frm_s = sync2_reg[3];
    wire logic order_s = sync2_reg[4];
    // Qualifiers, bus data and polarity; no reset, they settle before any strobe edge
    always_ff @(posedge clock_i) begin
        bus_sync1_reg <= {polarity_i, host_read_i, host_data_sel_i, host_bus_lines_i};
        bus_sync2_reg <= bus_sync1_reg;
    end
    wire logic pol_s = bus_sync2_reg[10];
    wire logic rd_s = bus_sync2_reg[9];
    wire logic dsel_s = bus_sync2_reg[8];
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            en_d_reg <= 1'b0;
            cl_d_reg <= 1'b0;
        end else begin
            en_d_reg <= en_s;
            cl_d_reg <= cl_s;
        end
    end
    wire logic en_fall = en_d_reg & ~en_s;
    wire logic cl_fall = cl_d_reg & ~cl_s;
    wire logic cl_rise = ~cl_d_reg & cl_s;

    ////////////////////////////////////////////////////////////////////////
    // Host access decode
    logic [3:0] busy_cnt_reg;
    wire logic busy = (busy_cnt_reg != 4'h0);
    wire logic stat_rd = rd_s & ~dsel_s;
    wire logic take = en_fall & ~stat_rd & rst_n_s & ~busy;
    wire logic instr = take & ~rd_s & ~dsel_s;
    wire logic dwr = take & ~rd_s & dsel_s;
    wire logic drd = take & rd_s & dsel_s;
    wire logic [7:0] d = bus_sync2_reg[7:0];

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            busy_cnt_reg <= 4'h0;
        end else if (take) begin
            busy_cnt_reg <= 4'(BUSY_CYC);
        end else if (busy) begin
            busy_cnt_reg <= busy_cnt_reg - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address registers
    logic [PAGE_W-1:0] page_reg;
    logic [COL_W-1:0] col_reg;
    logic [LINE_W-1:0] start_reg;
    logic on_reg;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            page_reg <= PAGE_RST;
        end else if (instr && d[7:3] == PAGE_CODE) begin
            page_reg <= d[PAGE_W-1:0];
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            col_reg <= COL_RST;
        end else if (instr && d[7:6] == COL_CODE) begin
            col_reg <= d[COL_W-1:0];
        end else if (dwr || drd) begin
            col_reg <= (col_reg == COL_MAX) ? COL_RST : col_reg + 6'h01;
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i || !rst_n_s) begin
            start_reg <= START_RST;
        end else if (instr && d[7:6] == START_CODE) begin
            start_reg <= d[LINE_W-1:0];
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i || !rst_n_s) begin
            on_reg <= 1'b0;
        end else if (instr && d[7:1] == ONOFF_CODE) begin
            on_reg <= d[0];
        end
    end
    assign display_on_o = on_reg;

    ////////////////////////////////////////////////////////////////////////
    // Display RAM, page-major byte address
    logic [7:0] ram [RAM_DEPTH];
    logic [7:0] out_reg;
    // Reversed order mirrors the column address into the array
    wire logic [COL_W-1:0] col_phys = order_s ? col_reg : COL_MAX - col_reg;
    wire logic [8:0] host_addr = {page_reg, col_phys};
    always_ff @(posedge clock_i) begin
        if (dwr) begin
            ram[host_addr] <= d;
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            out_reg <= 8'h00;
        end else if (drd) begin
            out_reg <= ram[host_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host read-back
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            host_bus_lines_o <= 8'h00;
        end else if (stat_rd) begin
            host_bus_lines_o <= 8'h00;
            host_bus_lines_o[BUSY_BIT] <= busy;
            host_bus_lines_o[OFF_BIT] <= ~on_reg;
            host_bus_lines_o[RST_BIT] <= ~rst_n_s;
        end else begin
            host_bus_lines_o <= out_reg;
        end
    end
    assign host_bus_lines_oe_o = en_s & rd_s;

    ////////////////////////////////////////////////////////////////////////
    // Refresh scan
    logic [LINE_W-1:0] line_reg;
    logic [SEG_N-1:0] latch_reg;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            line_reg <= START_RST;
        end else if (frm_s) begin
            line_reg <= start_reg;
        end else if (cl_fall) begin
            line_reg <= line_reg + 6'h01;
        end
    end
    // One bit from each column byte of the addressed line
    logic [SEG_N-1:0] row_bits;
    always_comb begin
        row_bits = '0;
        for (int c = 0; c < SEG_N; c++) begin
            row_bits[c] = ram[{line_reg[5:3], 6'(c)}][line_reg[2:0]];
        end
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            latch_reg <= '0;
        end else if (cl_rise) begin
            latch_reg <= on_reg ? row_bits : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment drivers
    wire logic [2*SEG_N-1:0] level_bus;
    for (genvar s = 0; s < SEG_N; s++) begin : g_seg
        seg_level_sel u_sel (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .data_i(latch_reg[s]),
            .polarity_i(pol_s),
            .level_o(level_bus[2*s+1:2*s])
        );
    end
    assign seg_level_o = level_bus;
endmodule
`default_nettype wire

// *** sim/lcd_host_model.sv ***
// Purpose: Host processor model on the parallel bus
// Assumes: Drives at the falling clock edge
// Notes: Fixed gap after each strobe covers the busy time
`timescale 1ns/100ps
`default_nettype none
module lcd_host_model (
    // Clock
    input wire logic clock_i,
    // Bus
    input wire logic [7:0] rd_i,
    output logic en_o,
    output logic rw_o,
    output logic ds_o,
    output logic [7:0] wd_o
);
    initial begin
        {en_o, rw_o, ds_o, wd_o} = 11'h000;
    end
    task automatic acc(input logic rw, input logic ds, input logic [7:0] d, output logic [7:0] q);
        @(negedge clock_i);
        rw_o = rw;
        ds_o = ds;
        wd_o = rw ? ~wd_o : d;
        en_o = 1'b1;
        repeat (5) @(negedge clock_i);
        q = rd_i;
        en_o = 1'b0;
        repeat (8) @(negedge clock_i);
    endtask
    task automatic poll(output logic [7:0] q);
        for (int i = 0; i < 40; i++) begin
            acc(1'b1, 1'b0, 8'h00, q);
            if ((q & 8'h90) === 8'h00) break;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/lcd_scan_assertions.sv ***
// Purpose: Port checker for the column driver
// Assumes: Sees only top module ports
// Notes: Windows cover the input sync latency
`timescale 1ns/100ps
`default_nettype none
module lcd_scan_assertions (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Watched ports
    input wire logic host_enable_i,
    input wire logic host_read_i,
    input wire logic host_data_sel_i,
    input wire logic [7:0] host_bus_lines_o,
    input wire logic host_bus_lines_oe_o,
    input wire logic reset_n_i,
    input wire logic polarity_i,
    input wire logic [2*lcd_scan_pkg::SEG_N-1:0] seg_level_o,
    input wire logic display_on_o
);
    import lcd_scan_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence status_sel;
        (!host_data_sel_i && host_read_i) [*5];
    endsequence
    sequence held_low;
        !reset_n_i [*4];
    endsequence
    oe_idle_a: assert property (!host_enable_i [*3] |-> !host_bus_lines_oe_o)
        else $error("bus driven while idle");
    rst_off_a: assert property (held_low |-> !display_on_o)
        else $error("display on under reset");
    rst_flag_a: assert property ((!reset_n_i && !host_data_sel_i && host_read_i) [*5]
        |-> host_bus_lines_o[RST_BIT]) else $error("reset flag clear");
    off_flag_a: assert property ((!host_data_sel_i && host_read_i && $stable(display_on_o)) [*5]
        |-> host_bus_lines_o[OFF_BIT] == !display_on_o) else $error("off flag wrong");
    stat_zero_a: assert property (status_sel |-> (host_bus_lines_o & 8'h4F) == 8'h00)
        else $error("status spare bits set");
    level_pol_a: assert property ($stable(polarity_i) [*3]
        |-> (seg_level_o & {SEG_N{2'h1}}) == (polarity_i ? '0 : {SEG_N{2'h1}}))
        else $error("level against polarity");
    on_gate_a: assert property ($rose(display_on_o) |-> $past(reset_n_i, 3))
        else $error("instruction taken in reset");
    on_hold_a: assert property ((host_enable_i && reset_n_i) [*4] |-> $stable(display_on_o))
        else $error("display state moved alone");
endmodule
bind lcd_column_ram_scan_control lcd_scan_assertions lcd_scan_assertions_i (
    .clock_i(clock_i), .reset_i(reset_i), .host_enable_i(host_enable_i),
    .host_read_i(host_read_i), .host_data_sel_i(host_data_sel_i),
    .host_bus_lines_o(host_bus_lines_o), .host_bus_lines_oe_o(host_bus_lines_oe_o),
    .reset_n_i(reset_n_i), .polarity_i(polarity_i), .seg_level_o(seg_level_o),
    .display_on_o(display_on_o));
`default_nettype wire

// *** sim/test_lcd_column_ram_scan_control.sv ***
// Purpose: Self-checking bench for the column driver
// Assumes: Host model does all bus cycles
// Notes: Segment order changes only while the device is held in reset
`timescale 1ns/100ps
`default_nettype none
module test_lcd_column_ram_scan_control;
    import lcd_scan_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic reset_n = 1'b0;
    logic lsc = 1'b0;
    logic frame_start = 1'b0;
    logic pol = 1'b1;
    logic order = 1'b1;
    logic en, rw, ds, oe, on;
    logic [7:0] wd, rd, q;
    logic [2*SEG_N-1:0] seg;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    always #2 clock_i = ~clock_i;
    lcd_host_model lcd_host_model_i (.clock_i(clock_i), .rd_i(rd), .en_o(en), .rw_o(rw),
        .ds_o(ds), .wd_o(wd));
    lcd_column_ram_scan_control lcd_column_ram_scan_control_i (.clock_i(clock_i),
        .reset_i(reset_i), .host_enable_i(en), .host_read_i(rw), .host_data_sel_i(ds),
        .host_bus_lines_i(wd), .host_bus_lines_o(rd), .host_bus_lines_oe_o(oe),
        .reset_n_i(reset_n), .seg_order_i(order), .line_shift_clock_i(lsc),
        .frame_start_i(frame_start), .polarity_i(pol), .seg_level_o(seg), .display_on_o(on));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic r, input logic d, input logic [7:0] v);
        lcd_host_model_i.acc(r, d, v, q);
    endtask
    // Rising then falling line clock with the given frame level
    task automatic line(input logic f);
        frame_start = f;
        repeat (6) @(negedge clock_i);
        lsc = 1'b1;
        repeat (8) @(negedge clock_i);
        lsc = 1'b0;
        repeat (8) @(negedge clock_i);
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(negedge clock_i);
        reset_i = 1'b0;
        acc(0, 0, 8'h3F);
        chk(on, 0);
        acc(1, 0, 0);
        chk(q, 8'h30);
        reset_n = 1'b1;
        lcd_host_model_i.poll(q);
        chk(q, 8'h20);
        acc(0, 0, 8'h3F);
        chk(on, 1);
        $display("test reset done");
        acc(0, 0, {PAGE_CODE, 3'h2});
        acc(0, 0, {COL_CODE, 6'h3F});
        acc(0, 1, 8'hA5);
        acc(0, 1, 8'h5A);
        acc(0, 0, {COL_CODE, 6'h3F});
        acc(1, 1, 0);
        acc(1, 1, 0);
        chk(q, 8'hA5);
        acc(1, 1, 0);
        chk(q, 8'h5A);
        $display("test ram done");
        acc(0, 0, {PAGE_CODE, 3'h0});
        acc(0, 0, {COL_CODE, 6'h00});
        acc(0, 1, 8'h01);
        acc(0, 1, 8'h00);
        line(1);
        chk(seg[3:0], {LVL_V3, LVL_V1});
        pol = 1'b0;
        repeat (4) @(negedge clock_i);
        chk(seg[3:0], {LVL_V4, LVL_V2});
        acc(0, 0, 8'h3E);
        line(1);
        chk(seg[3:0], {LVL_V4, LVL_V4});
        acc(0, 0, 8'h3F);
        line(1);
        chk(seg[1:0], LVL_V2);
        acc(0, 0, {START_CODE, 6'h01});
        line(1);
        chk(seg[1:0], LVL_V4);
        acc(0, 0, {PAGE_CODE, 3'h7});
        acc(0, 0, {COL_CODE, 6'h00});
        acc(0, 1, 8'h00);
        acc(0, 0, {START_CODE, 6'h3F});
        line(1);
        line(0);
        chk(seg[1:0], LVL_V4);
        line(0);
        chk(seg[1:0], LVL_V2);
        $display("test scan done");
        reset_n = 1'b0;
        acc(1, 0, 0);
        chk(q, 8'h30);
        chk(on, 0);
        acc(0, 0, 8'h3F);
        chk(on, 0);
        order = 1'b0;
        reset_n = 1'b1;
        lcd_host_model_i.poll(q);
        chk(q, 8'h20);
        acc(0, 0, 8'h3F);
        acc(0, 0, {START_CODE, 6'h00});
        acc(0, 0, {PAGE_CODE, 3'h0});
        acc(0, 0, {COL_CODE, 6'h00});
        acc(0, 1, 8'h01);
        line(1);
        chk(seg[127:126], LVL_V2);
        chk(oe, 0);
        $display("test restart done");
        print_verdict();
    end
endmodule
`default_nettype wire
